//--- dspt_load.sv
// External load on one compare output pin, counting its high cycles
`timescale 1ns/1ps
module dspt_load (
	// Clock
	input  wire logic clk,
	// Pin from the timer
	input  wire logic pin,
	input  wire logic pin_en,
	// Measurement window and result
	input  wire logic en,
	output int        high_cnt
);
	// --------------------
	// Line level
	// --------------------
	logic level;

	// A pull-down holds the line low whenever the timer lets go of it
	assign level = pin_en ? pin : 1'b0;

	always_ff @(posedge clk) begin
		if (!en)
			high_cnt <= 0;
		else if (level === 1'b1)
			high_cnt <= high_cnt + 1;
	end
endmodule // dspt_load

//--- dspt_pkg.sv
// Constants and types shared by the dual-slope PWM timer files
package dspt_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int unsigned DSPT_ADDR_W = 8;
	localparam int unsigned DSPT_DATA_W = 32;
	localparam int unsigned DSPT_CNT_W  = 16;
	localparam int unsigned DSPT_CS_W   = 3;

	typedef logic [DSPT_CNT_W-1:0] dspt_cnt_t;
	typedef logic [3:0]            dspt_mode_t;
	typedef logic [1:0]            dspt_com_t;
	typedef logic [DSPT_CS_W-1:0]  dspt_cs_t;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] DSPT_OFF_CTRL  = 8'h00;
	localparam logic [7:0] DSPT_OFF_COUNT = 8'h04;
	localparam logic [7:0] DSPT_OFF_CMPA  = 8'h08;
	localparam logic [7:0] DSPT_OFF_CMPB  = 8'h0c;
	localparam logic [7:0] DSPT_OFF_ICAP  = 8'h10;
	localparam logic [7:0] DSPT_OFF_FLAGS = 8'h14;

	// ------------------------------------------------------------
	// Control fields, flag bits, reset values
	// ------------------------------------------------------------
	localparam int unsigned DSPT_CTL_MODE_LSB = 0;
	localparam int unsigned DSPT_CTL_COMA_LSB = 4;
	localparam int unsigned DSPT_CTL_COMB_LSB = 6;
	localparam int unsigned DSPT_CTL_CS_LSB   = 8;
	localparam int unsigned DSPT_CTL_DIRA_BIT = 12;
	localparam int unsigned DSPT_CTL_DIRB_BIT = 13;
	localparam int unsigned DSPT_CTL_W        = 14;
	localparam logic [DSPT_CTL_W-1:0] DSPT_CTL_RST = 14'h0000;

	localparam int unsigned DSPT_FLG_OVF  = 0;
	localparam int unsigned DSPT_FLG_CMPA = 1;
	localparam int unsigned DSPT_FLG_CMPB = 2;
	localparam int unsigned DSPT_FLG_ICAP = 3;
	localparam int unsigned DSPT_FLG_W    = 4;
	localparam logic [DSPT_FLG_W-1:0] DSPT_FLG_RST = 4'h0;

	// ------------------------------------------------------------
	// Waveform modes and TOP values
	// ------------------------------------------------------------
	localparam dspt_mode_t DSPT_MODE_PC8      = 4'h1;
	localparam dspt_mode_t DSPT_MODE_PC9      = 4'h2;
	localparam dspt_mode_t DSPT_MODE_PC10     = 4'h3;
	localparam dspt_mode_t DSPT_MODE_PFC_ICAP = 4'h8;
	localparam dspt_mode_t DSPT_MODE_PFC_CMPA = 4'h9;
	localparam dspt_mode_t DSPT_MODE_PC_ICAP  = 4'ha;
	localparam dspt_mode_t DSPT_MODE_PC_CMPA  = 4'hb;

	localparam dspt_cnt_t DSPT_TOP_8   = 16'h00ff;
	localparam dspt_cnt_t DSPT_TOP_9   = 16'h01ff;
	localparam dspt_cnt_t DSPT_TOP_10  = 16'h03ff;
	localparam dspt_cnt_t DSPT_TOP_MAX = 16'hffff;
	localparam dspt_cnt_t DSPT_BOTTOM  = 16'h0000;
	localparam dspt_cnt_t DSPT_ONE     = 16'h0001;

	// ------------------------------------------------------------
	// Compare output select and prescaler select
	// ------------------------------------------------------------
	localparam dspt_com_t DSPT_COM_OFF    = 2'h0;
	localparam dspt_com_t DSPT_COM_TOGGLE = 2'h1;
	localparam dspt_com_t DSPT_COM_NONINV = 2'h2;
	localparam dspt_com_t DSPT_COM_INV    = 2'h3;

	localparam dspt_cs_t DSPT_CS_STOP    = 3'h0;
	localparam dspt_cs_t DSPT_CS_DIV1    = 3'h1;
	localparam dspt_cs_t DSPT_CS_DIV8    = 3'h2;
	localparam dspt_cs_t DSPT_CS_DIV64   = 3'h3;
	localparam dspt_cs_t DSPT_CS_DIV256  = 3'h4;
	localparam dspt_cs_t DSPT_CS_DIV1024 = 3'h5;

	// Divider exponents for 8, 64, 256, 1024: 3, 6, 8, 10
	localparam int unsigned DSPT_EXP_DIV8    = 3;
	localparam int unsigned DSPT_EXP_DIV64   = 6;
	localparam int unsigned DSPT_EXP_DIV256  = 8;
	localparam int unsigned DSPT_EXP_DIV1024 = 10;

	// Count direction, one-hot
	typedef enum logic [1:0] {
		DSPT_DIR_UP   = 2'b01,
		DSPT_DIR_DOWN = 2'b10
	} dspt_dir_t;

endpackage

//--- dspt_prescaler.sv
// Prescaler making the timer clock enable from the I/O clock
`timescale 1ns/1ps
module dspt_prescaler #(
	parameter int unsigned PRE_W = 10
) (
	// Clock and reset
	input  wire logic   pclk,
	input  wire logic   presetn,
	// Select in, tick out
	dspt_tick_if.pre    tk
);
	import dspt_pkg::*;

	// Elaboration-time refusal of a counter too short for the largest divider
	if (PRE_W < DSPT_EXP_DIV1024) begin : g_bad_pre_w
		$error("dspt_prescaler: PRE_W too small for divide by 1024");
	end

	logic [PRE_W-1:0] pre_q;
	logic [PRE_W-1:0] pre_d;

	function automatic logic [PRE_W-1:0] low_mask(input int unsigned e);
		low_mask = PRE_W'((1 << e) - 1);
	endfunction

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	always_comb begin
		pre_d = (tk.csel == DSPT_CS_STOP) ? '0 : pre_q + PRE_W'(1);
		case (tk.csel)
			DSPT_CS_DIV1:    tk.tick = 1'b1;
			DSPT_CS_DIV8:    tk.tick = (pre_q & low_mask(DSPT_EXP_DIV8)) == '0;
			DSPT_CS_DIV64:   tk.tick = (pre_q & low_mask(DSPT_EXP_DIV64)) == '0;
			DSPT_CS_DIV256:  tk.tick = (pre_q & low_mask(DSPT_EXP_DIV256)) == '0;
			DSPT_CS_DIV1024: tk.tick = (pre_q & low_mask(DSPT_EXP_DIV1024)) == '0;
			default:         tk.tick = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pre_q <= '0;
		else
			pre_q <= pre_d;
	end

endmodule // dspt_prescaler

//--- dspt_tick_if.sv
// Prescaler select and timer tick between timer core and prescaler
`timescale 1ns/1ps
interface dspt_tick_if;
	import dspt_pkg::*;
	dspt_cs_t csel;
	logic     tick;
	modport ctl (output csel, input tick);
	modport pre (input csel, output tick);
endinterface

//--- dspt_timer.sv
// Dual-slope PWM timer with APB registers and two compare outputs
`timescale 1ns/1ps
module dspt_timer
	import dspt_pkg::*;
#(
	parameter int unsigned PRE_W = 10
) (
	// Clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [dspt_pkg::DSPT_ADDR_W-1:0] paddr,
	input  wire logic [dspt_pkg::DSPT_DATA_W-1:0] pwdata,
	output logic      [dspt_pkg::DSPT_DATA_W-1:0] prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Compare output pins
	output logic                               oc_a_pin,
	output logic                               oc_a_oe,
	output logic                               oc_b_pin,
	output logic                               oc_b_oe
);
	import dspt_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic is_dual(input dspt_mode_t m);
		case (m)
			DSPT_MODE_PC8, DSPT_MODE_PC9, DSPT_MODE_PC10,
			DSPT_MODE_PFC_ICAP, DSPT_MODE_PFC_CMPA,
			DSPT_MODE_PC_ICAP, DSPT_MODE_PC_CMPA: is_dual = 1'b1;
			default: is_dual = 1'b0;
		endcase
	endfunction

	function automatic logic is_pfc(input dspt_mode_t m);
		is_pfc = (m == DSPT_MODE_PFC_ICAP) || (m == DSPT_MODE_PFC_CMPA);
	endfunction

	function automatic logic a_is_top(input dspt_mode_t m);
		a_is_top = (m == DSPT_MODE_PFC_CMPA) || (m == DSPT_MODE_PC_CMPA);
	endfunction

	function automatic logic icap_is_top(input dspt_mode_t m);
		icap_is_top = (m == DSPT_MODE_PFC_ICAP) || (m == DSPT_MODE_PC_ICAP);
	endfunction

	// Bits kept by a compare write; fixed TOP values are all-ones masks
	function automatic dspt_cnt_t res_mask(input dspt_mode_t m);
		case (m)
			DSPT_MODE_PC8:  res_mask = DSPT_TOP_8;
			DSPT_MODE_PC9:  res_mask = DSPT_TOP_9;
			DSPT_MODE_PC10: res_mask = DSPT_TOP_10;
			default:        res_mask = DSPT_TOP_MAX;
		endcase
	endfunction

	function automatic dspt_cnt_t top_of(input dspt_mode_t m,
		input dspt_cnt_t icap, input dspt_cnt_t cmpa);
		if (a_is_top(m))
			top_of = cmpa;
		else if (icap_is_top(m))
			top_of = icap;
		else
			top_of = res_mask(m);
	endfunction

	function automatic logic mapped(input logic [DSPT_ADDR_W-1:0] a);
		case (a)
			DSPT_OFF_CTRL, DSPT_OFF_COUNT, DSPT_OFF_CMPA,
			DSPT_OFF_CMPB, DSPT_OFF_ICAP, DSPT_OFF_FLAGS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	// Next level of a compare output on a match
	function automatic logic pwm_next(input dspt_com_t com,
		input logic cur, input logic hit, input logic up, input logic tgl);
		pwm_next = cur;
		if (hit) begin
			case (com)
				DSPT_COM_NONINV: pwm_next = !up;
				DSPT_COM_INV:    pwm_next = up;
				DSPT_COM_TOGGLE: pwm_next = tgl ? !cur : cur;
				default:         pwm_next = cur;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [DSPT_CTL_W-1:0]  ctrl_q, ctrl_d;
	dspt_cnt_t              cnt_q, cnt_d;
	dspt_dir_t              dir_q, dir_d, dir_nx;
	dspt_cnt_t              cnt_nx;
	dspt_cnt_t              abuf_q, abuf_d, bbuf_q, bbuf_d;
	dspt_cnt_t              cmpa_q, cmpa_d, cmpb_q, cmpb_d;
	dspt_cnt_t              icap_q, icap_d;
	logic [DSPT_FLG_W-1:0]  flg_q, flg_d, flg_set, flg_clr;
	logic                   oca_q, oca_d, ocb_q, ocb_d;
	logic [DSPT_DATA_W-1:0] rdata_q, rdata_d;

	dspt_mode_t mode;
	dspt_com_t  com_a, com_b;
	dspt_cnt_t  top;
	logic       dual, run, at_top, at_bot, upd_pt, going_up;
	logic       hit_a, hit_b, tgl_ok, wr, wr_cnt;

	dspt_tick_if tk ();

	dspt_prescaler #(.PRE_W(PRE_W)) u_pre (
		.pclk    (pclk),
		.presetn (presetn),
		.tk      (tk.pre)
	);

	assign mode     = ctrl_q[DSPT_CTL_MODE_LSB +: 4];
	assign com_a    = ctrl_q[DSPT_CTL_COMA_LSB +: 2];
	assign com_b    = ctrl_q[DSPT_CTL_COMB_LSB +: 2];
	assign tk.csel  = ctrl_q[DSPT_CTL_CS_LSB +: DSPT_CS_W];
	assign dual     = is_dual(mode);
	assign top      = top_of(mode, icap_q, cmpa_q);
	assign run      = tk.tick && dual;
	assign at_top   = cnt_q == top;
	assign at_bot   = cnt_q == DSPT_BOTTOM;
	assign upd_pt   = is_pfc(mode) ? at_bot : at_top;
	assign hit_a    = run && (cnt_q == cmpa_q);
	assign hit_b    = run && (cnt_q == cmpb_q);
	assign tgl_ok   = a_is_top(mode);
	assign wr       = psel && penable && pwrite && mapped(paddr);
	assign wr_cnt   = wr && (paddr == DSPT_OFF_COUNT);

	// ------------------------------------------------------------
	// Counter direction
	// ------------------------------------------------------------
	always_comb begin
		case (dir_q)
			DSPT_DIR_UP: begin
				if (at_top) begin
					dir_nx = DSPT_DIR_DOWN;
					cnt_nx = cnt_q - DSPT_ONE;
				end else begin
					dir_nx = DSPT_DIR_UP;
					cnt_nx = cnt_q + DSPT_ONE;
				end
			end
			DSPT_DIR_DOWN: begin
				if (at_bot) begin
					dir_nx = DSPT_DIR_UP;
					cnt_nx = cnt_q + DSPT_ONE;
				end else begin
					dir_nx = DSPT_DIR_DOWN;
					cnt_nx = cnt_q - DSPT_ONE;
				end
			end
			default: begin
				dir_nx = DSPT_DIR_UP;
				cnt_nx = DSPT_BOTTOM;
			end
		endcase
		// The slope a value belongs to is the one leaving it
		going_up = dir_nx == DSPT_DIR_UP;
	end

	// ------------------------------------------------------------
	// Next state of the timer and register file
	// ------------------------------------------------------------
	always_comb begin
		ctrl_d  = ctrl_q;
		cnt_d   = run ? cnt_nx : cnt_q;
		dir_d   = run ? dir_nx : dir_q;
		abuf_d  = abuf_q;
		bbuf_d  = bbuf_q;
		icap_d  = icap_q;
		cmpa_d  = cmpa_q;
		cmpb_d  = cmpb_q;
		flg_clr = '0;

		// Outside the dual-slope modes nothing is double buffered
		if (!dual) begin
			cmpa_d = abuf_q;
			cmpb_d = bbuf_q;
		end else if (run && upd_pt) begin
			cmpa_d = abuf_q;
			cmpb_d = bbuf_q;
		end

		if (wr) begin
			case (paddr)
				DSPT_OFF_CTRL:  ctrl_d = pwdata[DSPT_CTL_W-1:0];
				DSPT_OFF_COUNT: cnt_d  = pwdata[DSPT_CNT_W-1:0];
				DSPT_OFF_CMPA:
					abuf_d = pwdata[DSPT_CNT_W-1:0] & res_mask(mode);
				DSPT_OFF_CMPB:
					bbuf_d = pwdata[DSPT_CNT_W-1:0] & res_mask(mode);
				DSPT_OFF_ICAP:  icap_d = pwdata[DSPT_CNT_W-1:0];
				DSPT_OFF_FLAGS: flg_clr = pwdata[DSPT_FLG_W-1:0];
				default:        ctrl_d = ctrl_q;
			endcase
		end

		flg_set = '0;
		flg_set[DSPT_FLG_OVF]  = run && at_bot;
		flg_set[DSPT_FLG_CMPA] = hit_a || (run && at_top && a_is_top(mode));
		flg_set[DSPT_FLG_CMPB] = hit_b;
		flg_set[DSPT_FLG_ICAP] = run && at_top && icap_is_top(mode);
		// A flag raised in the cycle it is cleared survives
		flg_d = (flg_q & ~flg_clr) | flg_set;

		oca_d = pwm_next(com_a, oca_q, hit_a, going_up, tgl_ok);
		ocb_d = pwm_next(com_b, ocb_q, hit_b, going_up, 1'b0);

		// Read data is prepared in the setup phase
		rdata_d = rdata_q;
		if (psel && !penable && !pwrite) begin
			rdata_d = '0;
			case (paddr)
				DSPT_OFF_CTRL:  rdata_d[DSPT_CTL_W-1:0] = ctrl_q;
				DSPT_OFF_COUNT: rdata_d[DSPT_CNT_W-1:0] = cnt_q;
				DSPT_OFF_CMPA:  rdata_d[DSPT_CNT_W-1:0] = abuf_q;
				DSPT_OFF_CMPB:  rdata_d[DSPT_CNT_W-1:0] = bbuf_q;
				DSPT_OFF_ICAP:  rdata_d[DSPT_CNT_W-1:0] = icap_q;
				DSPT_OFF_FLAGS: rdata_d[DSPT_FLG_W-1:0] = flg_q;
				default:        rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= DSPT_CTL_RST;
			cnt_q   <= DSPT_BOTTOM;
			dir_q   <= DSPT_DIR_UP;
			abuf_q  <= DSPT_BOTTOM;
			bbuf_q  <= DSPT_BOTTOM;
			cmpa_q  <= DSPT_BOTTOM;
			cmpb_q  <= DSPT_BOTTOM;
			icap_q  <= DSPT_BOTTOM;
			flg_q   <= DSPT_FLG_RST;
			oca_q   <= 1'b0;
			ocb_q   <= 1'b0;
			rdata_q <= '0;
		end else begin
			ctrl_q  <= ctrl_d;
			cnt_q   <= cnt_d;
			dir_q   <= dir_d;
			abuf_q  <= abuf_d;
			bbuf_q  <= bbuf_d;
			cmpa_q  <= cmpa_d;
			cmpb_q  <= cmpb_d;
			icap_q  <= icap_d;
			flg_q   <= flg_d;
			oca_q   <= oca_d;
			ocb_q   <= ocb_d;
			rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// Bus answer and pins
	// ------------------------------------------------------------
	assign prdata  = rdata_q;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);

	// Toggle select drives only output A, and only with compare A as TOP
	assign oc_a_pin = oca_q;
	assign oc_b_pin = ocb_q;
	assign oc_a_oe = ctrl_q[DSPT_CTL_DIRA_BIT] && (com_a[1] ||
		(com_a == DSPT_COM_TOGGLE && tgl_ok));
	assign oc_b_oe = ctrl_q[DSPT_CTL_DIRB_BIT] && com_b[1];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	top_fixed_a: assert property (
		run && mode == DSPT_MODE_PC8 && cnt_q == DSPT_TOP_8 &&
		dir_q == DSPT_DIR_UP && !wr |=> dir_q == DSPT_DIR_DOWN)
		else $error("8-bit TOP did not reverse the count");
	slope_up_a: assert property (
		run && dir_q == DSPT_DIR_UP && !at_top && !wr_cnt
		|=> cnt_q == $past(cnt_q) + DSPT_ONE)
		else $error("up slope did not step by one");
	top_hold_a: assert property (
		run && at_top && dir_q == DSPT_DIR_UP && !wr_cnt
		|=> dir_q == DSPT_DIR_DOWN && cnt_q == $past(cnt_q) - DSPT_ONE)
		else $error("count did not leave TOP after one tick");
	ovf_bottom_a: assert property (
		run && at_bot |=> flg_q[DSPT_FLG_OVF])
		else $error("overflow flag missing at bottom");
	pc_update_a: assert property (
		run && at_top && !is_pfc(mode) |=> cmpa_q == $past(abuf_q))
		else $error("phase correct compare not loaded at TOP");
	pfc_update_a: assert property (
		run && at_bot && is_pfc(mode)
		|=> cmpb_q == $past(bbuf_q) && flg_q[DSPT_FLG_OVF])
		else $error("bottom update or overflow missing");
	top_flag_a: assert property (
		run && at_top && icap_is_top(mode) |=> flg_q[DSPT_FLG_ICAP])
		else $error("capture flag missing at TOP");
	pin_gate_a: assert property (
		!ctrl_q[DSPT_CTL_DIRA_BIT] |-> !oc_a_oe)
		else $error("pin A driven while direction is input");
	up_clear_a: assert property (
		hit_a && com_a == DSPT_COM_NONINV && going_up |=> !oc_a_pin)
		else $error("non-inverted output not cleared on up match");
	zero_low_a: assert property (
		dual && com_a == DSPT_COM_NONINV && cmpa_q == DSPT_BOTTOM &&
		abuf_q == DSPT_BOTTOM && !oc_a_pin && !wr |=> !oc_a_pin)
		else $error("zero compare let output rise");
	toggle_a: assert property (
		hit_a && com_a == DSPT_COM_TOGGLE && tgl_ok
		|=> oc_a_pin != $past(oc_a_pin))
		else $error("output A did not toggle");
	mask_write_a: assert property (
		wr && paddr == DSPT_OFF_CMPA && mode == DSPT_MODE_PC8
		|=> (abuf_q & ~DSPT_TOP_8) == DSPT_BOTTOM)
		else $error("compare bits above resolution kept");
	match_flag_a: assert property (
		hit_b |=> flg_q[DSPT_FLG_CMPB])
		else $error("compare B flag missing on match");
	tick_gate_a: assert property (
		!tk.tick && !wr_cnt |=> $stable(cnt_q))
		else $error("count moved without a tick");

	reach_top_c:   cover property (run && at_top && a_is_top(mode));
	pfc_bottom_c:  cover property (run && at_bot && is_pfc(mode));
	toggle_out_c:  cover property (hit_a && com_a == DSPT_COM_TOGGLE);
	clear_race_c:  cover property (|(flg_set & flg_clr));

endmodule // dspt_timer

//--- dual_slope_pwm_timer_tb_top.sv
// Self-checking testbench for the dual-slope PWM timer
`timescale 1ns/1ps
module dual_slope_pwm_timer_tb_top;
	import dspt_pkg::*;

	// --------------------
	// Signals
	// --------------------
	typedef struct {
		dspt_mode_t m;
		dspt_cs_t   cs;
		int         dv;
		dspt_cnt_t  t;
		dspt_cnt_t  ca;
		dspt_cnt_t  cb;
		dspt_com_t  pa;
		dspt_com_t  pb;
		logic [1:0] dir;
	} dspt_row_t;

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err;
	logic        oa, oa_e, ob, ob_e;
	logic        en      = 1'b0;
	int          ha, hb;
	int          mismatches   = 0;
	int          total_checks = 0;

	// Fixed TOPs, capture TOP, compare A TOP; each row ends on a full window
	dspt_row_t rows [9] = '{
		'{4'h1, 3'h1, 1, 16'h00ff, 16'h0040, 16'h0000, 2'h2, 2'h3, 2'b11},
		'{4'h2, 3'h1, 1, 16'h01ff, 16'h01ff, 16'h0100, 2'h2, 2'h3, 2'b11},
		'{4'h3, 3'h1, 1, 16'h03ff, 16'h0000, 16'h03ff, 2'h2, 2'h2, 2'b11},
		'{4'h8, 3'h2, 8, 16'h0010, 16'h0005, 16'h0003, 2'h2, 2'h3, 2'b11},
		'{4'h9, 3'h1, 1, 16'h0020, 16'h0020, 16'h0008, 2'h1, 2'h2, 2'b11},
		'{4'ha, 3'h5, 1024, 16'h0003, 16'h0001, 16'h0002, 2'h3, 2'h2, 2'b11},
		'{4'hb, 3'h4, 256, 16'h000c, 16'h000c, 16'h000c, 2'h1, 2'h1, 2'b11},
		'{4'h1, 3'h1, 1, 16'h00ff, 16'h0000, 16'h0040, 2'h3, 2'h2, 2'b10},
		'{4'ha, 3'h3, 64, 16'h0005, 16'h0002, 16'h0005, 2'h1, 2'h0, 2'b11}
	};

	always #50 pclk = ~pclk;

	// --------------------
	// Design and loads
	// --------------------
	dspt_timer #(.PRE_W(10)) u_dspt_timer (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .oc_a_pin(oa), .oc_a_oe(oa_e),
		.oc_b_pin(ob), .oc_b_oe(ob_e));
	dspt_load u_dspt_load_a (.clk(pclk), .pin(oa), .pin_en(oa_e), .en(en),
		.high_cnt(ha));
	dspt_load u_dspt_load_b (.clk(pclk), .pin(ob), .pin_en(ob_e), .en(en),
		.high_cnt(hb));

	// --------------------
	// Tasks
	// --------------------
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask

	// One APB transfer, then an idle cycle
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	function automatic logic [31:0] ctl(dspt_row_t r, dspt_cs_t cs);
		return {18'h0, r.dir, 1'b0, cs, r.pb, r.pa, r.m};
	endfunction

	// High cycles over two timer periods
	function automatic int hi(dspt_com_t p, dspt_cnt_t c, int t, int dv,
		logic drv);
		if (!drv)
			return 0;
		case (p)
		2'h1: return 2 * t * dv;
		2'h2: return 4 * c * dv;
		2'h3: return 4 * (t - c) * dv;
		default: return 0;
		endcase
	endfunction

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#9_000_000;
		mismatches++;
		$display("BAD watchdog exp done got timeout");
		complete_run();
	end

	// --------------------
	// Tests
	// --------------------
	initial begin
		dspt_row_t  r;
		dspt_mode_t md;
		logic       da, db;
		int         v;
		int         nf [4];
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a < 'h1c; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			chk("reset_value", 32'h0, rd);
			chk("slverr", {31'h0, a == 'h18}, {31'h0, err});
		end
		wr(8'h18, 32'hffffffff);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped_read", 32'h0, rd);
		chk("oe_reset", 32'h0, {30'h0, oa_e, ob_e});
		wr(DSPT_OFF_CTRL, {28'h0, DSPT_MODE_PC10});
		wr(DSPT_OFF_CMPA, 32'h0000ffff);
		apb(1'b0, DSPT_OFF_CMPA, 32'h0);
		chk("cmpa_masked", {16'h0, DSPT_TOP_10}, rd);
		$display("test reset and registers done");
		foreach (rows[i]) begin
			r = rows[i];
			wr(DSPT_OFF_CTRL, ctl(r, DSPT_CS_STOP));
			wr(DSPT_OFF_ICAP, {16'h0, r.t});
			wr(DSPT_OFF_CMPA, {16'h0, r.ca});
			wr(DSPT_OFF_CMPB, {16'h0, r.cb});
			wr(DSPT_OFF_COUNT, 32'h0);
			wr(DSPT_OFF_CTRL, ctl(r, r.cs));
			repeat (4 * r.t * r.dv + 8) @(posedge pclk);
			en <= 1'b1;
			repeat (4 * r.t * r.dv) @(posedge pclk);
			en <= 1'b0;
			#1;
			da = r.dir[0] && (r.pa != DSPT_COM_TOGGLE ||
				r.m == DSPT_MODE_PFC_CMPA || r.m == DSPT_MODE_PC_CMPA);
			db = r.dir[1] && r.pb != DSPT_COM_TOGGLE;
			chk("high_a", hi(r.pa, r.ca, r.t, r.dv, da), ha);
			chk("high_b", hi(r.pb, r.cb, r.t, r.dv, db), hb);
			chk("drive_a", {31'h0, da && r.pa != 0}, {31'h0, oa_e});
			chk("drive_b", {31'h0, db && r.pb != 0}, {31'h0, ob_e});
			$display("test row %0d done", i);
		end
		// Count read mid-hold every 64 cycles; flags tallied over two periods
		for (int k = 0; k < 2; k++) begin
			md = k ? DSPT_MODE_PFC_ICAP : DSPT_MODE_PC_ICAP;
			wr(DSPT_OFF_CTRL, {28'h0, md});
			wr(DSPT_OFF_ICAP, 32'h5);
			wr(DSPT_OFF_COUNT, 32'h0);
			wr(DSPT_OFF_CTRL, {20'h0, 1'b0, DSPT_CS_DIV64, 4'h0, md});
			do apb(1'b0, DSPT_OFF_COUNT, 32'h0); while (rd === 32'h0);
			wr(DSPT_OFF_FLAGS, 32'hf);
			repeat (24) @(posedge pclk);
			nf = '{0, 0, 0, 0};
			for (int i = 1; i <= 21; i++) begin
				v = i % 10;
				apb(1'b0, DSPT_OFF_COUNT, 32'h0);
				chk("count", v <= 5 ? v : 10 - v, rd);
				apb(1'b0, DSPT_OFF_FLAGS, 32'h0);
				for (int b = 0; b < 4; b++)
					nf[b] += rd[b];
				wr(DSPT_OFF_FLAGS, 32'hf);
				repeat (55) @(posedge pclk);
			end
			chk("ovf_flags", 2, nf[DSPT_FLG_OVF]);
			chk("top_flags", 2, nf[DSPT_FLG_ICAP]);
			chk("cmpa_flags", 4, nf[DSPT_FLG_CMPA]);
			chk("cmpb_flags", 2, nf[DSPT_FLG_CMPB]);
			$display("test sequence %0d done", k);
		end
		// Reset in mid-run: control and pin drive must return to idle
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, DSPT_OFF_CTRL, 32'h0);
		chk("ctrl_after_reset", 32'h0, rd);
		chk("oe_after_reset", 32'h0, {30'h0, oa_e, ob_e});
		$display("test mid-run reset done");
		complete_run();
	end
endmodule // dual_slope_pwm_timer_tb_top
